// file: pkg/osp_consts.vh
// Constants for the origin search pulse block: offsets, fields, resets, timing
`ifndef OSP_CONSTS_VH
`define OSP_CONSTS_VH

// ======================================================================
// Register byte offsets
`define OSP_A_CFG      8'h00
`define OSP_A_INIT     8'h04
`define OSP_A_HIGH     8'h08
`define OSP_A_PROX     8'h0C
`define OSP_A_CMD      8'h10
`define OSP_A_STAT     8'h14
`define OSP_A_ISTAT    8'h18
`define OSP_A_IMASK    8'h1C
`define OSP_A_ACC      8'h20
`define OSP_A_POS      8'h24

// ======================================================================
// Configuration fields
`define OSP_C_LIM_ALWAYS 0
`define OSP_C_LIM_NC     1
`define OSP_C_CLR_ORG    2
`define OSP_C_SCURVE     3
`define OSP_C_SRCH_EN    4
`define OSP_C_DIR_CCW    5
`define OSP_C_PAT_LO     6
`define OSP_C_PAT_HI     7
`define OSP_C_LIM_ERR    8
`define OSP_C_ORG_NC     9
`define OSP_C_PROX_NC    10
`define OSP_CFG_W        11
`define OSP_CFG_RST      11'h602

// Command bits (write pulses)
`define OSP_K_SEARCH     0
`define OSP_K_STOP       1
`define OSP_K_JOG        2
`define OSP_K_JOG_CCW    3

// Interrupt event bits
`define OSP_E_DONE       0
`define OSP_E_REFUSE     1
`define OSP_E_LIMSTOP    2
`define OSP_E_SRCHERR    3
`define OSP_E_W          4

// ======================================================================
// Speeds and timing
`define OSP_SPD_W        17
`define OSP_SPD_MAX      17'h186A0
`define OSP_ACC_RST      17'h00064
`define OSP_PH_W         28
`define OSP_CLK_HZ       28'h5F5E100
`define OSP_CLK_NS       10
`define OSP_TICK_NS      1000000
`define OSP_TICK_CYC     (`OSP_TICK_NS / `OSP_CLK_NS)

`endif

// file: rtl/osp_in_cond.v
// Sensor input conditioner: synchroniser, polarity and edge detection
`timescale 1ns/1ps
module osp_in_cond (
    input  wire aclk,
    input  wire aresetn,
    input  wire ce,
    input  wire pin,
    input  wire nc,
    output wire lvl,
    output wire rise,
    output wire fall
);
    reg s1_reg;
    reg s2_reg;
    reg lvl_reg;

    // ==================================================================
    // Two-stage sync, then polarity, then edge history
    always @(posedge aclk) begin
        if (!aresetn) begin
            // Start at the idle pin level so no false edge follows reset
            s1_reg  <= nc;
            s2_reg  <= nc;
            lvl_reg <= 1'b0;
        end else if (ce) begin
            s1_reg  <= pin;
            s2_reg  <= s1_reg;
            lvl_reg <= s2_reg ^ nc;     // Closed contact reads inactive when nc is set
        end
    end

    assign lvl  = lvl_reg;
    assign rise = (s2_reg ^ nc) & ~lvl_reg;
    assign fall = ~(s2_reg ^ nc) & lvl_reg;
endmodule // osp_in_cond

// file: rtl/osp_origin_search.v
// Origin search, limit handling and pulse train generator with AXI4-Lite
// Function
// - In search-only mode the limits are acted on only during an origin search.
// - In always mode the limits also stop other motion such as jogging.
// - The limit inputs are read as normally closed or normally open per config.
// - Hold-origin: a limit stops pulses and keeps origin state and position.
// - Clear-origin: a limit stops pulses and marks the origin undefined.
// - Search and jog start at the initial rate, 0 to 100000 pulses/s.
// - A search is refused unless proximity > initial speed and, outside pattern 2, high > proximity.
// - Ramps are linear or S-curve as the speed-curve bit selects.
// - An origin search starts only while the search function is enabled.
// - The origin is taken at an origin rising edge met in the search direction.
// - A direction bit makes the search clockwise or counter-clockwise.
// - Pattern 0 needs proximity on then off, pattern 1 proximity on, first.
// - Pattern 2 ignores proximity and uses initial and proximity speeds, and high speed while turning back.
// - Reverse mode turns back when a limit hits in the search direction.
// - Stop-with-error mode halts and flags an error on that limit.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "osp_consts.vh"
module osp_origin_search #(
    parameter TICK_CYC = `OSP_TICK_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        lim_cw_in,
    input  wire        lim_ccw_in,
    input  wire        prox_in,
    input  wire        org_in,
    output reg         pulse_out,
    output reg         dir_ccw_out,
    output wire        irq
);
    localparam S_IDLE = 3'd0;
    localparam S_FAST = 3'd1;
    localparam S_POFF = 3'd2;
    localparam S_SLOW = 3'd3;
    localparam S_BACK = 3'd4;
    localparam S_JOG  = 3'd5;

    reg [`OSP_CFG_W-1:0] cfg_reg;
    reg [`OSP_SPD_W-1:0] init_reg, high_reg, prox_reg, acc_reg;
    reg [`OSP_E_W-1:0]   istat_reg, imask_reg;
    reg [2:0]            st_reg;
    reg                  org_def_reg, err_reg;
    reg [31:0]           pos_reg;
    reg [`OSP_SPD_W-1:0] spd_reg, jerk_reg;
    reg [`OSP_PH_W-1:0]  ph_reg;
    reg [16:0]           tick_reg;
    reg [7:0]            aw_a_reg;
    reg                  aw_have_reg, w_have_reg;
    reg [31:0]           w_d_reg;

    wire cw_l, ccw_l, pr_l, pr_r, pr_f, og_r, og_f;
    wire [1:0] pat = cfg_reg[`OSP_C_PAT_HI:`OSP_C_PAT_LO];
    wire srch_ccw  = cfg_reg[`OSP_C_DIR_CCW];

    // ==================================================================
    // Sensor conditioning
    // limit polarity, sync
    osp_in_cond u_cw (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(lim_cw_in),
        .nc(cfg_reg[`OSP_C_LIM_NC]), .lvl(cw_l), .rise(), .fall());
    osp_in_cond u_ccw (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(lim_ccw_in),
        .nc(cfg_reg[`OSP_C_LIM_NC]), .lvl(ccw_l), .rise(), .fall());
    osp_in_cond u_prx (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(prox_in),
        .nc(cfg_reg[`OSP_C_PROX_NC]), .lvl(pr_l), .rise(pr_r), .fall(pr_f));
    osp_in_cond u_org (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pin(org_in),
        .nc(cfg_reg[`OSP_C_ORG_NC]), .lvl(), .rise(og_r), .fall(og_f));

    // ==================================================================
    // AXI4-Lite handshakes
    wire do_wr  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire do_rd  = ce & s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_awready = ce & ~aw_have_reg;
    assign s_axi_wready  = ce & ~w_have_reg;
    assign s_axi_arready = ce & ~s_axi_rvalid;
    assign s_axi_bresp   = 2'b00;

    wire wr_cmd   = do_wr & (aw_a_reg == `OSP_A_CMD) & w_d_reg[`OSP_K_SEARCH];
    wire wr_stop  = do_wr & (aw_a_reg == `OSP_A_CMD) & w_d_reg[`OSP_K_STOP];
    wire wr_jog   = do_wr & (aw_a_reg == `OSP_A_CMD) & w_d_reg[`OSP_K_JOG];
    wire rd_istat = do_rd & (s_axi_araddr == `OSP_A_ISTAT);

    // ==================================================================
    // Search start qualification
    // speed ordering check
    wire spd_ok = (prox_reg > init_reg) & ((pat == 2'd2) | (high_reg > prox_reg));
    wire srch_ok = cfg_reg[`OSP_C_SRCH_EN] & spd_ok;
    wire moving  = (st_reg != S_IDLE);
    wire in_srch = moving & (st_reg != S_JOG);
    wire lim_fwd = dir_ccw_out ? ccw_l : cw_l;
    wire at_srch = (dir_ccw_out == srch_ccw);

    // ==================================================================
    // Sequencer next-state logic
    reg [2:0]            st_next;
    reg                  dir_next, stop_c, done_c, lim_c, err_c;
    reg [`OSP_SPD_W-1:0] tgt;
    always @* begin
        st_next  = st_reg;
        dir_next = dir_ccw_out;
        stop_c   = 1'b0;
        done_c   = 1'b0;
        lim_c    = 1'b0;
        err_c    = 1'b0;
        tgt      = high_reg;
        case (st_reg)
            S_IDLE: begin
                if (wr_cmd && srch_ok) begin
                    dir_next = srch_ccw;
                    st_next  = (pat == 2'd2) ? S_SLOW : S_FAST;
                end else if (wr_jog) begin
                    dir_next = w_d_reg[`OSP_K_JOG_CCW];
                    st_next  = S_JOG;
                end
            end
            S_FAST: begin
                if (pr_r)
                    st_next = (pat == 2'd0) ? S_POFF : S_SLOW;
            end
            S_POFF: begin
                tgt = prox_reg;
                if (pr_f)
                    st_next = S_SLOW;
            end
            S_SLOW: begin
                tgt = prox_reg;
                if (og_r && at_srch) begin
                    st_next = S_IDLE;
                    done_c  = 1'b1;
                end
            end
            S_BACK: begin
                // Leave the sensor zone, then search again
                if ((pat == 2'd2) ? og_f : pr_f) begin
                    dir_next = srch_ccw;
                    st_next  = (pat == 2'd2) ? S_SLOW : S_FAST;
                end
            end
            S_JOG: begin
                tgt = high_reg;
            end
            default: begin
                st_next = S_IDLE;
            end
        endcase
        // Limit in the direction of travel
        if (in_srch && lim_fwd) begin
            if (at_srch && !cfg_reg[`OSP_C_LIM_ERR]) begin
                dir_next = ~srch_ccw;
                st_next  = S_BACK;
            end else begin
                st_next = S_IDLE;
                err_c   = 1'b1;
                lim_c   = 1'b1;
            end
        end else if (st_reg == S_JOG && lim_fwd && cfg_reg[`OSP_C_LIM_ALWAYS]) begin
            st_next = S_IDLE;
            lim_c   = 1'b1;
        end
        if (wr_stop && moving) begin
            st_next = S_IDLE;
        end
        if (moving && st_next == S_IDLE)
            stop_c = 1'b1;
    end

    // ==================================================================
    // Ramp step size: fixed or growing towards the acceleration rate
    wire [`OSP_SPD_W-1:0] step = (cfg_reg[`OSP_C_SCURVE] && jerk_reg < acc_reg)
                                 ? jerk_reg : acc_reg;
    wire tick = (tick_reg == 17'd0);
    wire [`OSP_PH_W-1:0] ph_sum = ph_reg + {{(`OSP_PH_W-`OSP_SPD_W){1'b0}}, spd_reg};
    wire pulse_c = moving && (spd_reg != 0) && (ph_sum >= `OSP_CLK_HZ);

    // ==================================================================
    // Motion, position and origin state
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_reg      <= S_IDLE;
            dir_ccw_out <= 1'b0;
            spd_reg     <= 17'h00000;
            jerk_reg    <= 17'h00001;
            ph_reg      <= 28'h0000000;
            tick_reg    <= 17'h00000;
            pulse_out   <= 1'b0;
            pos_reg     <= 32'h00000000;
            org_def_reg <= 1'b0;
            err_reg     <= 1'b0;
        end else if (ce) begin
            st_reg      <= st_next;
            dir_ccw_out <= dir_next;
            pulse_out   <= pulse_c;
            tick_reg    <= tick ? TICK_CYC[16:0] - 17'd1 : tick_reg - 17'd1;
            ph_reg      <= !moving ? 28'h0000000 :
                           pulse_c ? ph_sum - `OSP_CLK_HZ : ph_sum;
            if (pulse_c)
                pos_reg <= dir_ccw_out ? pos_reg - 32'd1 : pos_reg + 32'd1;
            if (!moving && st_next != S_IDLE) begin
                spd_reg  <= init_reg;
                jerk_reg <= 17'h00001;
                err_reg  <= 1'b0;
            end else if (stop_c) begin
                spd_reg <= 17'h00000;
            end else if (moving && tick && spd_reg != tgt) begin
                jerk_reg <= jerk_reg + 17'd1;
                if (spd_reg < tgt)
                    spd_reg <= (tgt - spd_reg > step) ? spd_reg + step : tgt;
                else
                    spd_reg <= (spd_reg - tgt > step) ? spd_reg - step : tgt;
            end else if (moving && tick) begin
                jerk_reg <= 17'h00001;
            end
            if (err_c)
                err_reg <= 1'b1;
            if (lim_c && cfg_reg[`OSP_C_CLR_ORG])
                org_def_reg <= 1'b0;
            if (done_c) begin
                org_def_reg <= 1'b1;
                pos_reg     <= 32'h00000000;
            end
        end
    end

    // ==================================================================
    // Write channel and configuration registers
    wire [31:0] wd = w_d_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_a_reg     <= 8'h00;
            w_d_reg      <= 32'h00000000;
            s_axi_bvalid <= 1'b0;
            cfg_reg      <= `OSP_CFG_RST;
            init_reg     <= 17'h00000;
            high_reg     <= 17'h00000;
            prox_reg     <= 17'h00000;
            acc_reg      <= `OSP_ACC_RST;
            imask_reg    <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_have_reg) begin
                aw_have_reg <= 1'b1;
                aw_a_reg    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_reg) begin
                w_have_reg <= 1'b1;
                w_d_reg    <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_wr) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_a_reg)
                    `OSP_A_CFG:   cfg_reg   <= wd[`OSP_CFG_W-1:0];
                    `OSP_A_INIT:  init_reg  <= (wd[16:0] > `OSP_SPD_MAX) ? `OSP_SPD_MAX : wd[16:0];
                    `OSP_A_HIGH:  high_reg  <= (wd[16:0] > `OSP_SPD_MAX) ? `OSP_SPD_MAX : wd[16:0];
                    `OSP_A_PROX:  prox_reg  <= (wd[16:0] > `OSP_SPD_MAX) ? `OSP_SPD_MAX : wd[16:0];
                    `OSP_A_IMASK: imask_reg <= wd[`OSP_E_W-1:0];
                    `OSP_A_ACC:   acc_reg   <= wd[16:0];
                    default: ;
                endcase
            end
        end
    end

    // ==================================================================
    // Interrupt status: events set, read clears, set wins
    // refused start flag
    wire refuse_c = wr_cmd && !moving && !srch_ok;
    wire [`OSP_E_W-1:0] ev = {err_c, lim_c, refuse_c, done_c};
    always @(posedge aclk) begin
        if (!aresetn)
            istat_reg <= 4'h0;
        else if (ce)
            istat_reg <= (rd_istat ? 4'h0 : istat_reg) | ev;
    end
    assign irq = |(istat_reg & imask_reg);

    // ==================================================================
    // Read channel
    wire [31:0] stat_w = {21'h000000, err_reg, og_r, pr_l, ccw_l, cw_l,
                          st_reg, dir_ccw_out, org_def_reg, moving};
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (do_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `OSP_A_CFG:   s_axi_rdata <= {21'h000000, cfg_reg};
                    `OSP_A_INIT:  s_axi_rdata <= {15'h0000, init_reg};
                    `OSP_A_HIGH:  s_axi_rdata <= {15'h0000, high_reg};
                    `OSP_A_PROX:  s_axi_rdata <= {15'h0000, prox_reg};
                    `OSP_A_STAT:  s_axi_rdata <= stat_w;
                    `OSP_A_ISTAT: s_axi_rdata <= {28'h0000000, istat_reg};
                    `OSP_A_IMASK: s_axi_rdata <= {28'h0000000, imask_reg};
                    `OSP_A_ACC:   s_axi_rdata <= {15'h0000, acc_reg};
                    `OSP_A_POS:   s_axi_rdata <= pos_reg;
                    `OSP_A_CMD:   s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end
endmodule // osp_origin_search

// file: dv/osp_properties.sv
// Port-level assertions for the origin search block
`timescale 1ns/1ps
`include "osp_consts.vh"
module osp_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        lim_cw_in,
    input wire        lim_ccw_in,
    input wire        pulse_out,
    input wire        dir_ccw_out,
    input wire        irq
);
    // ==========================================================
    // Shadow of the configuration and mask words seen on the bus
    reg  [7:0]  wa_q;
    reg  [31:0] wd_q;
    reg         bv_q;
    reg  [10:0] cfg_q;
    reg  [3:0]  msk_q;
    wire        wr_now  = s_axi_bvalid && !bv_q;
    wire [3:0]  msk_now = (wr_now && wa_q == `OSP_A_IMASK) ? wd_q[3:0] : msk_q;
    wire        lim_hit = cfg_q[`OSP_C_LIM_ALWAYS]
                          && ((dir_ccw_out ? lim_ccw_in : lim_cw_in) ^ cfg_q[`OSP_C_LIM_NC]);

    // Capture address and data, apply when the response rises
    always @(posedge aclk) begin
        if (!aresetn) begin
            bv_q  <= 1'b0;
            cfg_q <= `OSP_CFG_RST;
            msk_q <= 4'h0;
        end else begin
            bv_q <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
            if (wr_now && wa_q == `OSP_A_CFG) cfg_q <= wd_q[10:0];
            msk_q <= msk_now;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence lim_held;
        lim_hit [*8];
    endsequence
    sequence stays_still;
        (!pulse_out && $stable(dir_ccw_out)) [*8];
    endsequence

    pulse_width_a: assert property (pulse_out |=> !pulse_out)
        else $error("step pulse wider than one cycle");
    dir_change_a: assert property ($changed(dir_ccw_out) |-> !pulse_out)
        else $error("direction changed on a step pulse");
    limit_stop_a: assert property (lim_held |-> !pulse_out)
        else $error("step pulse while a limit is active");
    refuse_start_a: assert property (
        wr_now && wa_q == `OSP_A_CMD && wd_q[`OSP_K_SEARCH] && !cfg_q[`OSP_C_SRCH_EN]
        |-> stays_still) else $error("disabled search produced motion");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    resp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
        else $error("write response not okay");
    irq_mask_a: assert property (msk_now == 4'h0 |-> !irq)
        else $error("interrupt with all events masked");
    irq_clear_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `OSP_A_ISTAT |=> !irq) else $error("interrupt after status read");
endmodule // osp_chk

bind osp_origin_search osp_chk chk (.*);

// file: dv/osp_motor_model.sv
// Motor and sensor model: counts steps and drives the sensor pins
`timescale 1ns/1ps
module osp_motor_model (
    input  wire  aclk,
    input  wire  step,
    input  wire  ccw,
    input  wire  inv,
    output logic lim_cw,
    output logic lim_ccw,
    output logic prox,
    output logic org
);
    integer pos = 0;

    // ==========================================================
    // Axis position follows each step pulse in its direction
    always @(posedge aclk) begin
        if (step) begin
            pos <= ccw ? pos - 1 : pos + 1;
        end
    end

    // Sensors along the axis; inv models normally closed contacts
    assign lim_cw  = (pos >= 12) ^ inv;
    assign lim_ccw = (pos <= -12) ^ inv;
    assign prox    = (pos >= 3 && pos <= 5) ^ inv;
    assign org     = (pos == 7 || pos == -2) ^ inv;
endmodule // osp_motor_model

// file: dv/test_osp_origin_search.sv
// Self-checking bench for the origin search block with a motor model
`timescale 1ns/1ps
`include "osp_consts.vh"
module test_osp_origin_search;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, inv, stuck;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  rr;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         lim_cw_in, lim_ccw_in, prox_in, org_in, pulse_out, dir_ccw_out, irq;
    integer      failures, num_checks, n;
    localparam integer GAP = `OSP_CLK_HZ / 60000;

    // ==========================================================
    // Design, motor model and clock
    osp_origin_search #(.TICK_CYC(20)) uut (.*);
    osp_motor_model mdl (.aclk(aclk), .step(pulse_out), .ccw(dir_ccw_out), .inv(inv),
        .lim_cw(lim_cw_in), .lim_ccw(lim_ccw_in), .prox(prox_in), .org(org_in));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
            end
        end
    endtask
    task automatic hang;
        begin
            failures = failures + 1;
            stuck = 1'b1;
            $display("unexpected at %0t: wait ran out", $time);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        integer k;
        begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            k = 0;
            do begin
                @(posedge aclk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                k++;
            end while (k < 40 && !s_axi_bvalid);
            if (k == 40) hang;
        end
    endtask
    task automatic rd(input [7:0] a);
        integer k;
        begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            k = 0;
            do begin
                @(posedge aclk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                k++;
            end while (k < 40 && !s_axi_rvalid);
            if (k == 40) hang;
            v  = s_axi_rdata;
            rr = s_axi_rresp;
        end
    endtask
    task automatic rc(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            rd(a);
            chk(v & m, e);
        end
    endtask
    task automatic idle;
        integer k;
        begin
            v = 32'h1;
            for (k = 0; k < 30000 && v[0] !== 1'b0; k++) rd(`OSP_A_STAT);
            if (k == 30000) hang;
        end
    endtask
    task automatic srch(input [31:0] cfg, input [31:0] dir, input [31:0] pos);
        begin
            wr(`OSP_A_CFG, cfg);
            wr(`OSP_A_CMD, 32'h1);
            for (n = 0; n < 3000 && !pulse_out; n++) @(posedge aclk);
            if (n == 3000) hang;
            chk({31'h0, dir_ccw_out}, dir);
            idle;
            chk(mdl.pos, pos);
            rc(`OSP_A_STAT, 32'h2, 32'h2);
            rc(`OSP_A_POS, 32'hFFFFFFFF, 32'h0);
            rc(`OSP_A_ISTAT, 32'hF, 32'h1);
        end
    endtask
    task conclude;
        begin
            if (failures == 0 && num_checks > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    // A wait that ran out ends the run
    always @(posedge aclk) begin
        if (stuck) conclude;
    end

    // ==========================================================
    // Main sequence
    initial begin
        failures = 0;
        num_checks = 0;
        stuck = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        inv = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
        {s_axi_bready, s_axi_rready} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`OSP_A_CFG, 32'h7FF, 32'h602);
        rc(`OSP_A_ACC, 32'h1FFFF, 32'h64);
        rd(8'h40);
        chk({30'h0, rr}, 32'h2);
        wr(`OSP_A_HIGH, 32'h1FFFF);
        rc(`OSP_A_HIGH, 32'h1FFFF, 32'h186A0);
        wr(`OSP_A_INIT, 32'hEA60);
        wr(`OSP_A_PROX, 32'h13880);
        wr(`OSP_A_ACC, 32'h4E20);
        wr(`OSP_A_IMASK, 32'hF);
        wr(`OSP_A_CMD, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rc(`OSP_A_STAT, 32'h1, 32'h0);
        rc(`OSP_A_ISTAT, 32'hF, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(`OSP_A_CFG, 32'h652);
        for (int i = 0; i < 2; i++) begin
            wr(`OSP_A_HIGH, i ? 32'h186A0 : 32'h13880);
            wr(`OSP_A_PROX, i ? 32'hEA60 : 32'h13880);
            wr(`OSP_A_CMD, 32'h1);
            rc(`OSP_A_ISTAT, 32'hF, 32'h2);
        end
        wr(`OSP_A_IMASK, 32'h0);
        wr(`OSP_A_CMD, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rc(`OSP_A_ISTAT, 32'hF, 32'h2);
        wr(`OSP_A_IMASK, 32'hF);
        wr(`OSP_A_PROX, 32'h13880);
        srch(32'h652, 32'h0, 32'h7);
        srch(32'h63A, 32'h1, 32'hFFFFFFFE);
        wr(`OSP_A_HIGH, 32'h0);
        wr(`OSP_A_ACC, 32'h0);
        srch(32'h692, 32'h0, 32'h7);
        chk({31'h0, n >= GAP - 20 && n <= GAP + 20}, 32'h1);
        wr(`OSP_A_HIGH, 32'h186A0);
        wr(`OSP_A_ACC, 32'h4E20);
        wr(`OSP_A_CFG, 32'h613);
        wr(`OSP_A_CMD, 32'h4);
        idle;
        chk(mdl.pos, 32'hC);
        rc(`OSP_A_STAT, 32'h2, 32'h2);
        rc(`OSP_A_POS, 32'hFFFFFFFF, 32'h5);
        rc(`OSP_A_ISTAT, 32'hF, 32'h4);
        wr(`OSP_A_CFG, 32'h612);
        wr(`OSP_A_CMD, 32'h4);
        for (n = 0; n < 1500 && !pulse_out; n++) @(posedge aclk);
        if (n == 1500) hang;
        wr(`OSP_A_CMD, 32'h2);
        chk(mdl.pos, 32'hD);
        rc(`OSP_A_ISTAT, 32'hF, 32'h0);
        srch(32'h6B2, 32'h1, 32'h7);
        wr(`OSP_A_CFG, 32'h617);
        wr(`OSP_A_CMD, 32'h4);
        idle;
        chk(mdl.pos, 32'hC);
        rc(`OSP_A_STAT, 32'h2, 32'h0);
        rc(`OSP_A_ISTAT, 32'hF, 32'h4);
        srch(32'h6B2, 32'h1, 32'h7);
        wr(`OSP_A_CFG, 32'h792);
        wr(`OSP_A_CMD, 32'h1);
        idle;
        chk(mdl.pos, 32'hC);
        rc(`OSP_A_STAT, 32'h400, 32'h400);
        rc(`OSP_A_ISTAT, 32'hF, 32'hC);
        inv <= 1'b0;
        wr(`OSP_A_CFG, 32'h090);
        rc(`OSP_A_STAT, 32'h40, 32'h40);
        srch(32'h090, 32'h1, 32'h7);
        conclude;
    end
endmodule // test_osp_origin_search
